// File: rtl/chan_div_pkg.sv
package chan_div_pkg;
	localparam int          ADDR_W             = 10;
	localparam int          DATA_W             = 8;
	localparam int          NUM_CH             = 2;
	localparam logic [9:0]  CH3_RATIO_ADDR     = 10'h018;
	localparam logic [9:0]  CH3_DRIVER_ADDR    = 10'h019;
	localparam logic [9:0]  CH4_RATIO_ADDR     = 10'h01A;
	localparam logic [9:0]  CH4_DRIVER_ADDR    = 10'h01B;
	localparam logic [9:0]  UPDATE_ADDR        = 10'h00F;
	localparam logic [7:0]  RATIO_RESET        = 8'h01;
	localparam logic [7:0]  RATIO_OFF          = 8'h00;
	localparam logic [7:0]  DRIVER_RESET       = 8'h24;
	localparam logic [7:0]  DRIVER_RW_MASK     = 8'h3E;
	localparam logic [7:0]  UPDATE_GO          = 8'h01;
	localparam int          SWING_HI           = 5;
	localparam int          SWING_LO           = 4;
	localparam int          TERM_BIT           = 3;
	localparam int          REG_BIT            = 2;
	localparam int          OUT_BIT            = 1;
	localparam int          CLEAR_BIT          = 0;
endpackage

// File: rtl/output_channel_divider_ctrl.sv
`timescale 1ns/10ps
// Function
// R1: A ratio N from 1 to 255 makes the channel divider divide its clock by N; at N of one the code drives a constant high instead of a clock.
// R2: A ratio of zero stops the channel divider so no divided clock appears.
// R3: Each ratio register resets to one and reads back what software wrote.
// R4: Writing one to bit 0 of a driver register clears that divider and the bit self-clears.
// R5: The divider clear acts at the write itself without waiting for the update strobe.
// R6: Software must write zeros into bits 7 and 6 of the driver registers.
// R7: Bits 5:4 select the swing code, lowest 00 to highest 11, reset 10.
// R8: Bit 3 turns the output termination on, reset zero.
// R9: Bit 2 enables the regulator with reset one, bit 1 enables the output with reset zero.
// R10: The fourth channel driver register matches the third in layout, defaults and clear behaviour.
// R11: Ratio and driver settings are staged and applied only on the update strobe.
module output_channel_divider_ctrl
	import chan_div_pkg::*;
(
	input  wire logic              clk_sys_in,
	input  wire logic              rst_n_in,
	input  wire logic [ADDR_W-1:0] addr_in,
	input  wire logic [DATA_W-1:0] wdata_in,
	input  wire logic              wr_in,
	input  wire logic              rd_in,
	output logic      [DATA_W-1:0] rdata_out,
	output logic      [1:0]        ch3_swing_code_out,
	output logic                   ch3_termination_on_out,
	output logic                   ch3_regulator_on_out,
	output logic                   ch3_output_on_out,
	output logic                   ch3_clk_out,
	output logic      [1:0]        ch4_swing_code_out,
	output logic                   ch4_termination_on_out,
	output logic                   ch4_regulator_on_out,
	output logic                   ch4_output_on_out,
	output logic                   ch4_clk_out
);
	logic [7:0] ch3_ratio_stage;
	logic [7:0] ch4_ratio_stage;
	logic [7:0] ch3_driver_settings;
	logic [7:0] ch4_driver_settings;
	logic [7:0] ch3_ratio;
	logic [7:0] ch4_ratio;
	logic [7:0] ch3_driver_live;
	logic [7:0] ch4_driver_live;
	logic       ch3_ratio_counter_clear;
	logic       ch4_ratio_counter_clear;
	logic       wr_ch3_ratio;
	logic       wr_ch4_ratio;
	logic       wr_ch3_drv;
	logic       wr_ch4_drv;
	logic       wr_update;
	logic [7:0] rd_mux;
	logic [7:0] wdata_masked;

	ratio_link_if ch3_link ();
	ratio_link_if ch4_link ();

	assign wr_ch3_ratio = wr_in && (addr_in == CH3_RATIO_ADDR);
	assign wr_ch4_ratio = wr_in && (addr_in == CH4_RATIO_ADDR);
	assign wr_ch3_drv   = wr_in && (addr_in == CH3_DRIVER_ADDR);
	assign wr_ch4_drv   = wr_in && (addr_in == CH4_DRIVER_ADDR);
	assign wr_update    = wr_in && (addr_in == UPDATE_ADDR) && ((wdata_in & UPDATE_GO) != 8'h00);
	// Reserved and clear bits are not stored, so they read as zero
	assign wdata_masked = wdata_in & DRIVER_RW_MASK; // R6 R7 R8 R9

	assign rd_mux = (addr_in == CH3_RATIO_ADDR)  ? ch3_ratio_stage :
	                (addr_in == CH4_RATIO_ADDR)  ? ch4_ratio_stage :
	                (addr_in == CH3_DRIVER_ADDR) ? ch3_driver_settings :
	                (addr_in == CH4_DRIVER_ADDR) ? ch4_driver_settings : 8'h00; // R3

	// Staging registers written by software
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ch3_ratio_stage     <= RATIO_RESET; // R3
			ch4_ratio_stage     <= RATIO_RESET; // R3
			ch3_driver_settings <= DRIVER_RESET; // R7 R8 R9
			ch4_driver_settings <= DRIVER_RESET; // R10
		end else begin
			if (wr_ch3_ratio)
				ch3_ratio_stage <= wdata_in;
			if (wr_ch4_ratio)
				ch4_ratio_stage <= wdata_in;
			if (wr_ch3_drv)
				ch3_driver_settings <= wdata_masked;
			if (wr_ch4_drv)
				ch4_driver_settings <= wdata_masked; // R10
		end
	end

	// Active copies, loaded only by the update strobe
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ch3_ratio       <= RATIO_RESET;
			ch4_ratio       <= RATIO_RESET;
			ch3_driver_live <= DRIVER_RESET;
			ch4_driver_live <= DRIVER_RESET;
		end else if (wr_update) begin
			ch3_ratio       <= ch3_ratio_stage; // R11
			ch4_ratio       <= ch4_ratio_stage; // R11
			ch3_driver_live <= ch3_driver_settings; // R11
			ch4_driver_live <= ch4_driver_settings; // R11
		end
	end

	// One-cycle divider clear straight from the write
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			ch3_ratio_counter_clear <= 1'b0;
			ch4_ratio_counter_clear <= 1'b0;
			rdata_out               <= 8'h00;
		end else begin
			ch3_ratio_counter_clear <= wr_ch3_drv && wdata_in[CLEAR_BIT]; // R4 R5
			ch4_ratio_counter_clear <= wr_ch4_drv && wdata_in[CLEAR_BIT]; // R10
			rdata_out               <= rd_in ? rd_mux : 8'h00;
		end
	end

	assign ch3_link.ratio = ch3_ratio;
	assign ch3_link.clear = ch3_ratio_counter_clear;
	assign ch4_link.ratio = ch4_ratio;
	assign ch4_link.clear = ch4_ratio_counter_clear;

	ratio_divider u_ch3_div (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.link       (ch3_link.div)
	);
	ratio_divider u_ch4_div (
		.clk_sys_in (clk_sys_in),
		.rst_n_in   (rst_n_in),
		.link       (ch4_link.div)
	);

	assign ch3_clk_out = ch3_link.clk_div; // R1 R2
	assign ch4_clk_out = ch4_link.clk_div;

	assign ch3_swing_code_out     = ch3_driver_live[SWING_HI:SWING_LO]; // R7
	assign ch3_termination_on_out = ch3_driver_live[TERM_BIT]; // R8
	assign ch3_regulator_on_out   = ch3_driver_live[REG_BIT]; // R9
	assign ch3_output_on_out      = ch3_driver_live[OUT_BIT]; // R9
	assign ch4_swing_code_out     = ch4_driver_live[SWING_HI:SWING_LO]; // R10
	assign ch4_termination_on_out = ch4_driver_live[TERM_BIT];
	assign ch4_regulator_on_out   = ch4_driver_live[REG_BIT];
	assign ch4_output_on_out      = ch4_driver_live[OUT_BIT];
endmodule

// File: rtl/ratio_divider.sv
`timescale 1ns/10ps
module ratio_divider
	import chan_div_pkg::*;
(
	input  wire logic    clk_sys_in,
	input  wire logic    rst_n_in,
	ratio_link_if.div    link
);
	logic [7:0] count;
	logic [7:0] next_count;
	logic       half;
	logic       next_half;
	logic       running;
	logic [7:0] half_point;
	logic       pulse;
	assign running    = (link.ratio != RATIO_OFF);
	assign half_point = {1'b0, link.ratio[7:1]};
	// A ratio lowered below the running count must wrap at once, not after 256 cycles
	assign next_count = (!running || link.clear || count >= link.ratio - 8'h01) ? 8'h00 : count + 8'h01;
	assign next_half  = running && !link.clear && (count < half_point);
	assign pulse      = (link.ratio == RATIO_RESET) ? 1'b1 : half;
	// Divide-by-one passes a constant-high enable rather than a real clock copy
	assign link.clk_div = running && !link.clear && pulse;
	always_ff @(posedge clk_sys_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			count <= 8'h00;
			half  <= 1'b0;
		end else begin
			count <= next_count; // R1 R2 R4
			half  <= next_half; // R1
		end
	end
endmodule

// File: rtl/ratio_link_if.sv
`timescale 1ns/10ps
interface ratio_link_if;
	logic [7:0] ratio;
	logic       clear;
	logic       clk_div;
	modport ctrl (output ratio, output clear, input clk_div);
	modport div  (input ratio, input clear, output clk_div);
endinterface

// File: test/output_channel_divider_ctrl_assertions.sv
`timescale 1ns/10ps
module output_channel_divider_ctrl_checker
	import chan_div_pkg::*;
(
	input wire logic              clk_sys_in,
	input wire logic              rst_n_in,
	input wire logic [ADDR_W-1:0] addr_in,
	input wire logic [DATA_W-1:0] wdata_in,
	input wire logic              wr_in,
	input wire logic              rd_in,
	input wire logic [DATA_W-1:0] rdata_out,
	input wire logic [1:0]        ch3_swing_code_out,
	input wire logic              ch3_output_on_out,
	input wire logic              ch3_clk_out,
	input wire logic [1:0]        ch4_swing_code_out,
	input wire logic              ch4_clk_out
);
	wire upd = wr_in && (addr_in == UPDATE_ADDR);
	default clocking @(posedge clk_sys_in); endclocking
	default disable iff (!rst_n_in);
	AST_RD_IDLE: assert property (!$past(rd_in) |-> rdata_out == 8'h00)
		else $error("read data not idle");
	AST_RD_CH3_DRV: assert property (rd_in && addr_in == CH3_DRIVER_ADDR |=> !rdata_out[7] && !rdata_out[0])
		else $error("ch3 driver readback bad");
	AST_RD_CH4_DRV: assert property (rd_in && addr_in == CH4_DRIVER_ADDR |=> !rdata_out[6] && !rdata_out[0])
		else $error("ch4 driver readback bad");
	AST_CH3_HOLD: assert property (!$past(upd) |-> $stable({ch3_swing_code_out, ch3_output_on_out}))
		else $error("ch3 moved without update");
	AST_CH4_HOLD: assert property (!$past(upd) |-> $stable(ch4_swing_code_out))
		else $error("ch4 moved without update");
	AST_CH3_CLEAR: assert property (wr_in && addr_in == CH3_DRIVER_ADDR && wdata_in[0] |-> ##[1:3] !ch3_clk_out)
		else $error("ch3 clear missing");
	AST_CH4_CLEAR: assert property (wr_in && addr_in == CH4_DRIVER_ADDR && wdata_in[0] |-> ##[1:3] !ch4_clk_out)
		else $error("ch4 clear missing");
	AST_RD_NONE: assert property (rd_in && addr_in == 10'h3FF |=> rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule
bind output_channel_divider_ctrl output_channel_divider_ctrl_checker u_output_channel_divider_ctrl_checker (.*);

// File: test/test_output_channel_divider_ctrl.sv
`timescale 1ns/10ps
module test_output_channel_divider_ctrl;
	import chan_div_pkg::*;
	logic clk_sys_in = 1'b0, rst_n_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic [ADDR_W-1:0] addr_in = '0;
	logic [DATA_W-1:0] wdata_in = '0, rdata_out;
	logic [1:0] ch3_swing_code_out, ch4_swing_code_out;
	logic ch3_termination_on_out, ch3_regulator_on_out, ch3_output_on_out, ch3_clk_out;
	logic ch4_termination_on_out, ch4_regulator_on_out, ch4_output_on_out, ch4_clk_out;
	int n_errors = 0, n_compared = 0;
	output_channel_divider_ctrl u_output_channel_divider_ctrl (.*);
	wire [4:0] ch3_drv = {ch3_swing_code_out, ch3_termination_on_out, ch3_regulator_on_out, ch3_output_on_out};
	wire [4:0] ch4_drv = {ch4_swing_code_out, ch4_termination_on_out, ch4_regulator_on_out, ch4_output_on_out};
	initial forever #10 clk_sys_in = ~clk_sys_in;
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_errors++;
			$display("FAIL at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic wr(input logic [9:0] a, input logic [7:0] d);
		@(posedge clk_sys_in);
		addr_in <= a;
		wdata_in <= d;
		wr_in <= 1'b1;
		@(posedge clk_sys_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [9:0] a, input logic [7:0] exp);
		@(posedge clk_sys_in);
		addr_in <= a;
		rd_in <= 1'b1;
		@(posedge clk_sys_in);
		rd_in <= 1'b0;
		#1 chk(rdata_out, exp);
	endtask
	// Count high cycles of both divided clocks once new ratios are active
	task automatic run(input logic [7:0] r3, input logic [7:0] r4, input int n, input int e3, input int e4);
		int c3 = 0;
		int c4 = 0;
		wr(CH3_RATIO_ADDR, r3);
		wr(CH4_RATIO_ADDR, r4);
		wr(UPDATE_ADDR, UPDATE_GO);
		repeat (2) @(posedge clk_sys_in);
		repeat (n) begin
			@(posedge clk_sys_in);
			#1 c3 += (ch3_clk_out === 1'b1);
			c4 += (ch4_clk_out === 1'b1);
		end
		chk(16'(c3), 16'(e3));
		chk(16'(c4), 16'(e4));
		rd(CH4_RATIO_ADDR, r4);
	endtask
	task automatic close_out;
		$display("Compared %0d, mismatches %0d", n_compared, n_errors);
		if (n_errors == 0 && n_compared > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#200000;
		n_errors++;
		close_out();
	end
	initial begin
		repeat (10) @(posedge clk_sys_in);
		rst_n_in <= 1'b1;
		#1 chk({ch3_drv, ch3_clk_out, ch4_drv, ch4_clk_out}, 12'h965);
		rd(CH3_RATIO_ADDR, RATIO_RESET);
		rd(CH4_RATIO_ADDR, RATIO_RESET);
		rd(CH3_DRIVER_ADDR, DRIVER_RESET);
		rd(CH4_DRIVER_ADDR, DRIVER_RESET);
		wr(10'h3FF, 8'hFF);
		rd(10'h3FF, 8'h00);
		rd(CH3_RATIO_ADDR, RATIO_RESET);
		wr(CH3_DRIVER_ADDR, 8'h3A);
		wr(CH4_DRIVER_ADDR, 8'h0C);
		rd(CH3_DRIVER_ADDR, 8'h3A);
		rd(CH4_DRIVER_ADDR, 8'h0C);
		chk({ch3_drv, ch4_drv}, 10'h252);
		wr(UPDATE_ADDR, UPDATE_GO);
		#1 chk({ch3_drv, ch4_drv}, 10'h3A6);
		wr(CH3_DRIVER_ADDR, 8'h01);
		#1 chk(ch3_drv, 5'h1D);
		chk(ch3_clk_out, 1'b0);
		@(posedge clk_sys_in);
		#1 chk(ch3_clk_out, 1'b1);
		rd(CH3_DRIVER_ADDR, 8'h00);
		wr(CH4_DRIVER_ADDR, 8'h0D);
		rd(CH4_DRIVER_ADDR, 8'h0C);
		run(8'h04, 8'h00, 8, 4, 0);
		run(8'h03, 8'h01, 9, 3, 9);
		run(8'hFF, 8'h02, 510, 254, 255);
		close_out();
	end
endmodule
